// ### core/event_detect_defines.svh
// offsets, field positions and reset values of the event detector
// assumes inclusion by bare name from every file that needs them
// Contract
// RL1 - select bit zero freefall, one motion
// RL2 - freefall ANDs axis conditions, motion ORs them
// RL3 - axis high above threshold, low otherwise
// RL4 - all axis enables zero disables detection
// RL5 - latch and select bits give four modes
// RL6 - only enabled axes form the event condition
// RL7 - decrement mode clears flag after debounce delay
// RL8 - clear mode drops flag at once, rearms
// RL9 - unlatched freefall read keeps event flag
// RL10 - flags follow live high-g while not frozen
// RL11 - latched flag sets at count, holds till read
// RL12 - latched freefall read clears flag and counter
// RL13 - latched freefall freezes axis flags till read
// RL14 - unlatched motion clears per clear mode
// RL15 - unlatched motion read changes nothing
// RL16 - latched motion read clears source and counter
// RL17 - latched motion holds axis flags till read
// RL18 - disabled axis flags read as zero
// RL19 - counter steps per sample, fires at setting
`ifndef EVENT_DETECT_DEFINES_SVH
`define EVENT_DETECT_DEFINES_SVH

// register indices, byte address is four times the index
`define IDX_CFG        6'h15
`define IDX_SRC        6'h16
`define IDX_THS        6'h17
`define IDX_CNT        6'h18
`define IDX_MODE       6'h19
`define IDX_STATUS     6'h20
`define IDX_MASK       6'h21

// field positions
`define CFG_LO_BIT     3
`define CFG_HI_BIT     7
`define SRC_EA_BIT     7
`define MODE_CLR_BIT   0
`define INT_EVENT_BIT  0

// reset values
`define RST_CFG        5'h00
`define RST_THS        8'h00
`define RST_CNT        8'h00
`define RST_CLR_MODE   1'b1
`define RST_STATUS     1'b0
`define RST_MASK       1'b0

`endif

// ### core/event_detect_pkg.sv
// types shared by the event detector files
// assumes nothing of its surroundings
package event_detect_pkg;

    typedef logic signed [11:0] accel_type;

    // x in the low bits so the struct indexes as an axis array
    typedef struct packed {
        accel_type z;
        accel_type y;
        accel_type x;
    } sample_type;

    typedef struct packed {
        logic latch;
        logic or_and_combine_select;
        logic z_en;
        logic y_en;
        logic x_en;
    } cfg_type;

endpackage

// ### core/axis_threshold_compare.sv
// magnitude compare of one axis against the threshold
// assumes a two's complement sample and an enable from config
`timescale 1ns/100ps

module axis_threshold_compare (
    input  wire logic        [7:0]  ths_i,
    input  wire logic signed [11:0] accel_i,
    input  wire logic               enable_i,
    output logic                    high_o,
    output logic                    low_o,
    output logic                    neg_o
);
    logic [11:0] mag;
    logic        over;

    assign mag    = accel_i[11] ? 12'(-accel_i) : 12'(accel_i);
    assign over   = mag[11:4] > ths_i;               // see RL3
    assign high_o = enable_i & over;                 // see RL18
    assign low_o  = enable_i & ~over;
    assign neg_o  = enable_i & over & accel_i[11];

endmodule

// ### core/debounce_counter.sv
// debounce counter and event flag of the detector
// assumes one sample strobe per output sample
`timescale 1ns/100ps

module debounce_counter (
    input  wire logic       ref_clk_i,
    input  wire logic       rst_i,
    input  wire logic       sample_i,
    input  wire logic       cond_i,
    input  wire logic       latch_i,
    input  wire logic       clear_mode_i,
    input  wire logic       read_clear_i,
    input  wire logic [7:0] setting_i,
    output logic            active_o,
    output logic [7:0]      count_o
);
    logic [8:0] inc;
    logic       hit;

    assign inc = {1'b0, count_o} + 9'h001;
    assign hit = sample_i & cond_i & (inc >= {1'b0, setting_i}); // see RL19

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            count_o <= 8'h00;
        end else if (latch_i && read_clear_i) begin
            count_o <= 8'h00;                        // see RL12, RL16
        end else if (sample_i) begin
            if (cond_i) begin
                if (count_o < setting_i) begin
                    count_o <= inc[7:0];             // see RL19
                end
            end else if (clear_mode_i) begin
                count_o <= 8'h00;                    // see RL8
            end else if (count_o != 8'h00) begin
                count_o <= count_o - 8'h01;          // see RL7
            end
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            active_o <= 1'b0;
        end else if (hit) begin
            active_o <= 1'b1;                        // see RL11
        end else if (latch_i) begin
            if (read_clear_i) begin
                active_o <= 1'b0;                    // see RL12, RL16
            end
        end else if (sample_i && !cond_i) begin
            if (clear_mode_i || count_o <= 8'h01) begin
                active_o <= 1'b0;                    // see RL7, RL14
            end
        end
    end

    dec_hold_a : assert property ( // see RL7
        @(posedge ref_clk_i) disable iff (rst_i)
        (!latch_i && !clear_mode_i && active_o && count_o > 8'h01
         && sample_i && !cond_i) |=> active_o
    ) else $error("decrement mode dropped event too early");

endmodule

// ### core/freefall_motion_event_detector.sv
// freefall and motion event detector with an apb register slave
// assumes apb and the sample strobe synchronous to ref_clk_i
`timescale 1ns/100ps
`include "event_detect_defines.svh"

module freefall_motion_event_detector (
    input  wire logic                         ref_clk_i,
    input  wire logic                         rst_i,
    input  wire logic                         psel_i,
    input  wire logic                         penable_i,
    input  wire logic                         pwrite_i,
    input  wire logic [7:0]                   paddr_i,
    input  wire logic [31:0]                  pwdata_i,
    input  wire logic                         sample_valid_i,
    input  wire event_detect_pkg::sample_type sample_i,
    output logic                              pready_o,
    output logic [31:0]                       prdata_o,
    output logic                              pslverr_o,
    output logic                              event_active_o,
    output logic                              irq_o
);
    import event_detect_pkg::*;

    cfg_type          cfg_reg;
    logic [7:0]       ths_reg;
    logic [7:0]       cnt_reg;
    logic             clear_mode_reg;
    logic             int_status_reg;
    logic             int_mask_reg;
    logic             ea_prev_reg;
    logic [5:0]       flags_reg;

    logic [2:0][11:0] axes;
    logic [2:0]       axis_en;
    logic [2:0]       high_w;
    logic [2:0]       low_w;
    logic [2:0]       neg_w;
    logic [5:0]       live_flags;
    logic [5:0]       en_mask;
    logic             cond;
    logic             ea_w;
    logic [7:0]       count_w;
    logic             frozen;

    logic             setup;
    logic             access;
    logic             wr;
    logic             src_read;
    logic             mapped;
    logic [31:0]      rd_val;

    // byte address of a register index
    function automatic logic reg_hit(input logic [7:0] addr,
                                     input logic [5:0] idx);
        reg_hit = (addr == {idx, 2'b00});
    endfunction

    // apb phase decode
    assign setup    = psel_i & ~penable_i;
    assign access   = psel_i & penable_i & pready_o;
    assign wr       = access & pwrite_i;
    assign src_read = access & ~pwrite_i & reg_hit(paddr_i, `IDX_SRC);

    // per-axis comparators, x at index zero
    assign axes    = sample_i;
    assign axis_en = {cfg_reg.z_en, cfg_reg.y_en, cfg_reg.x_en};

    genvar i;
    generate
        for (i = 0; i < 3; i++) begin : g_axis
            axis_threshold_compare u_cmp (
                .ths_i    (ths_reg),
                .accel_i  (axes[i]),
                .enable_i (axis_en[i]),
                .high_o   (high_w[i]),
                .low_o    (low_w[i]),
                .neg_o    (neg_w[i])
            );
            assign live_flags[2*i+1] = high_w[i];    // see RL10
            assign live_flags[2*i]   = neg_w[i];
            assign en_mask[2*i+1]    = axis_en[i];   // see RL18
            assign en_mask[2*i]      = axis_en[i];
        end
    endgenerate

    // combined condition over the enabled axes
    always_comb begin
        if (axis_en == 3'b000) begin
            cond = 1'b0;                             // see RL4
        end else if (cfg_reg.or_and_combine_select) begin
            cond = |(high_w & axis_en);              // see RL1, RL2, RL6
        end else begin
            cond = &(low_w | ~axis_en);              // see RL1, RL2, RL6
        end
    end

    // latch and select bits pick one of four modes
    debounce_counter u_debounce (                    // see RL5
        .ref_clk_i    (ref_clk_i),
        .rst_i        (rst_i),
        .sample_i     (sample_valid_i),
        .cond_i       (cond),
        .latch_i      (cfg_reg.latch),
        .clear_mode_i (clear_mode_reg),
        .read_clear_i (src_read),                    // see RL9, RL15
        .setting_i    (cnt_reg),
        .active_o     (ea_w),
        .count_o      (count_w)
    );

    assign event_active_o = ea_w;

    // axis flags freeze only while a latched event is active
    assign frozen = cfg_reg.latch & ea_w;            // see RL13, RL17

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            flags_reg <= 6'h00;
        end else if (!frozen && sample_valid_i) begin
            flags_reg <= live_flags;                 // see RL10
        end else if (cfg_reg.latch && src_read) begin
            flags_reg <= 6'h00;                      // see RL16
        end
    end

    // configuration register
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cfg_reg <= cfg_type'(`RST_CFG);
        end else if (wr && reg_hit(paddr_i, `IDX_CFG)) begin
            cfg_reg <= cfg_type'(pwdata_i[`CFG_HI_BIT:`CFG_LO_BIT]);
        end
    end

    // threshold and debounce setting
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ths_reg <= `RST_THS;
        end else if (wr && reg_hit(paddr_i, `IDX_THS)) begin
            ths_reg <= pwdata_i[7:0];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            cnt_reg <= `RST_CNT;
        end else if (wr && reg_hit(paddr_i, `IDX_CNT)) begin
            cnt_reg <= pwdata_i[7:0];
        end
    end

    // debounce clear mode
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            clear_mode_reg <= `RST_CLR_MODE;
        end else if (wr && reg_hit(paddr_i, `IDX_MODE)) begin
            clear_mode_reg <= pwdata_i[`MODE_CLR_BIT];
        end
    end

    // interrupt: sticky event bit, write one to clear, set wins
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            ea_prev_reg <= 1'b0;
        end else begin
            ea_prev_reg <= ea_w;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_status_reg <= `RST_STATUS;
        end else if (ea_w && !ea_prev_reg) begin
            int_status_reg <= 1'b1;
        end else if (wr && reg_hit(paddr_i, `IDX_STATUS)
                     && pwdata_i[`INT_EVENT_BIT]) begin
            int_status_reg <= 1'b0;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            int_mask_reg <= `RST_MASK;
        end else if (wr && reg_hit(paddr_i, `IDX_MASK)) begin
            int_mask_reg <= pwdata_i[`INT_EVENT_BIT];
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            irq_o <= 1'b0;
        end else begin
            irq_o <= int_status_reg & int_mask_reg;
        end
    end

    // read mux
    always_comb begin
        rd_val = 32'h0000_0000;
        mapped = 1'b1;
        if (reg_hit(paddr_i, `IDX_CFG)) begin
            rd_val[`CFG_HI_BIT:`CFG_LO_BIT] = cfg_reg;
        end else if (reg_hit(paddr_i, `IDX_SRC)) begin
            rd_val[`SRC_EA_BIT] = ea_w;
            rd_val[5:0] = flags_reg & en_mask;       // see RL18
        end else if (reg_hit(paddr_i, `IDX_THS)) begin
            rd_val[7:0] = ths_reg;
        end else if (reg_hit(paddr_i, `IDX_CNT)) begin
            rd_val[7:0] = cnt_reg;
        end else if (reg_hit(paddr_i, `IDX_MODE)) begin
            rd_val[`MODE_CLR_BIT] = clear_mode_reg;
        end else if (reg_hit(paddr_i, `IDX_STATUS)) begin
            rd_val[`INT_EVENT_BIT] = int_status_reg;
        end else if (reg_hit(paddr_i, `IDX_MASK)) begin
            rd_val[`INT_EVENT_BIT] = int_mask_reg;
        end else begin
            mapped = 1'b0;
        end
    end

    // apb answer: ready in the first access cycle
    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pready_o <= 1'b0;
        end else begin
            pready_o <= setup;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            prdata_o <= 32'h0000_0000;
        end else if (setup && !pwrite_i) begin
            prdata_o <= rd_val;
        end else begin
            prdata_o <= 32'h0000_0000;
        end
    end

    always_ff @(posedge ref_clk_i or posedge rst_i) begin
        if (rst_i) begin
            pslverr_o <= 1'b0;
        end else begin
            pslverr_o <= setup & ~mapped;
        end
    end

    // checks

    apb_ready_a : assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        setup |=> pready_o ##1 !pready_o
    ) else $error("apb ready not a single access cycle");

    detect_off_a : assert property ( // see RL4
        @(posedge ref_clk_i) disable iff (rst_i)
        (axis_en == 3'b000) |-> !cond
    ) else $error("condition raised with all axes disabled");

    motion_or_a : assert property ( // see RL2
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_reg.or_and_combine_select && (high_w & axis_en) != 3'b000)
        |-> cond
    ) else $error("motion mode missed an enabled high axis");

    freefall_and_a : assert property ( // see RL1
        @(posedge ref_clk_i) disable iff (rst_i)
        (!cfg_reg.or_and_combine_select && cond)
        |-> (high_w & axis_en) == 3'b000
    ) else $error("freefall condition with an axis high");

    count_zero_a : assert property ( // see RL19
        @(posedge ref_clk_i) disable iff (rst_i)
        (cnt_reg == 8'h00 && sample_valid_i && cond) |=> ea_w
    ) else $error("zero debounce did not fire at once");

    latch_hold_a : assert property ( // see RL11
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_reg.latch && ea_w && !src_read) |=> ea_w
    ) else $error("latched event flag dropped without read");

    latch_read_a : assert property ( // see RL12
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_reg.latch && src_read && !sample_valid_i)
        |=> (!ea_w && count_w == 8'h00)
    ) else $error("latched read did not clear flag and counter");

    flags_frozen_a : assert property ( // see RL13
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_reg.latch && ea_w && !src_read) |=> $stable(flags_reg)
    ) else $error("axis flags moved while latched event active");

    unlatched_read_a : assert property ( // see RL15
        @(posedge ref_clk_i) disable iff (rst_i)
        (!cfg_reg.latch && src_read && !sample_valid_i)
        |=> ($stable(ea_w) && $stable(count_w) && $stable(flags_reg))
    ) else $error("unlatched read changed detector state");

    clear_fast_a : assert property ( // see RL8
        @(posedge ref_clk_i) disable iff (rst_i)
        (!cfg_reg.latch && clear_mode_reg && ea_w
         && sample_valid_i && !cond) |=> (!ea_w && count_w == 8'h00)
    ) else $error("clear mode did not drop the event at once");

    live_flags_a : assert property ( // see RL10
        @(posedge ref_clk_i) disable iff (rst_i)
        (!cfg_reg.latch && sample_valid_i)
        |=> (flags_reg == $past(live_flags))
    ) else $error("unlatched axis flags not following samples");

    src_mask_a : assert property ( // see RL18
        @(posedge ref_clk_i) disable iff (rst_i)
        (setup && !pwrite_i && reg_hit(paddr_i, `IDX_SRC)
         && !cfg_reg.z_en) |=> (prdata_o[5:4] == 2'b00)
    ) else $error("disabled axis flags read nonzero");

    irq_path_a : assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (ea_w && !ea_prev_reg && int_mask_reg && !psel_i)
        |=> ##1 irq_o
    ) else $error("unmasked event did not raise interrupt");

    int_set_a : assert property (
        @(posedge ref_clk_i) disable iff (rst_i)
        (ea_w && !ea_prev_reg) |=> int_status_reg
    ) else $error("event rise did not set interrupt status");

    ff_read_keep_a : assert property ( // see RL9
        @(posedge ref_clk_i) disable iff (rst_i)
        (!cfg_reg.latch && !cfg_reg.or_and_combine_select && ea_w
         && src_read && !sample_valid_i) |=> ea_w
    ) else $error("unlatched freefall read dropped the event");

    src_clear_a : assert property ( // see RL16
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_reg.latch && src_read && !sample_valid_i)
        |=> (flags_reg == 6'h00)
    ) else $error("latched read left axis flags set");

    motion_hold_a : assert property ( // see RL17
        @(posedge ref_clk_i) disable iff (rst_i)
        (cfg_reg.latch && cfg_reg.or_and_combine_select && ea_w
         && !src_read) |=> $stable(flags_reg)
    ) else $error("latched motion axis flags moved");

endmodule

// ### dv/freefall_motion_event_detector_test.sv
// self-checking bench for the freefall and motion event detector
// assumes the detector's own package and defines header are compiled first
`timescale 1ns/100ps
`include "event_detect_defines.svh"

module freefall_motion_event_detector_test;
    import event_detect_pkg::*;

    localparam logic [7:0] a_cfg  = {`IDX_CFG, 2'b00};
    localparam logic [7:0] a_src  = {`IDX_SRC, 2'b00};
    localparam logic [7:0] a_ths  = {`IDX_THS, 2'b00};
    localparam logic [7:0] a_cnt  = {`IDX_CNT, 2'b00};
    localparam logic [7:0] a_mode = {`IDX_MODE, 2'b00};
    localparam logic [7:0] a_stat = {`IDX_STATUS, 2'b00};
    localparam logic [7:0] a_mask = {`IDX_MASK, 2'b00};
    localparam accel_type  hi     = 12'sh200;
    localparam accel_type  lo     = 12'sh010;
    localparam accel_type  ng     = 12'shE00;

    logic        ref_clk_i = 1'b0;
    logic        rst_i;
    logic        psel_i;
    logic        penable_i;
    logic        pwrite_i;
    logic [7:0]  paddr_i;
    logic [31:0] pwdata_i;
    logic        sample_valid_i;
    sample_type  sample_i;
    logic        pready_o;
    logic [31:0] prdata_o;
    logic        pslverr_o;
    logic        event_active_o;
    logic        irq_o;
    logic [31:0] rd;
    logic        er;
    int          fails;
    int          cmp_count;
    int          cycles;

    freefall_motion_event_detector u_dut (
        .ref_clk_i      (ref_clk_i),
        .rst_i          (rst_i),
        .psel_i         (psel_i),
        .penable_i      (penable_i),
        .pwrite_i       (pwrite_i),
        .paddr_i        (paddr_i),
        .pwdata_i       (pwdata_i),
        .sample_valid_i (sample_valid_i),
        .sample_i       (sample_i),
        .pready_o       (pready_o),
        .prdata_o       (prdata_o),
        .pslverr_o      (pslverr_o),
        .event_active_o (event_active_o),
        .irq_o          (irq_o)
    );

    always #5 ref_clk_i = ~ref_clk_i;

    task automatic close_out();
        $display("compares %0d mismatches %0d", cmp_count, fails);
        if (fails == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 20000) begin
            fails++;
            $display("timeout");
            close_out();
        end
    end

    task automatic chk_word(string nm, logic [31:0] e, logic [31:0] g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    task automatic chk_bit(string nm, logic e, logic g);
        cmp_count++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %b seen %b", nm, e, g);
        end
    endtask

    // one apb transfer, held until pready is sampled high
    task automatic apb(logic wr, logic [7:0] a, logic [31:0] d);
        @(posedge ref_clk_i);
        psel_i    <= 1'b1;
        pwrite_i  <= wr;
        paddr_i   <= a;
        pwdata_i  <= d;
        @(posedge ref_clk_i);
        penable_i <= 1'b1;
        do begin
            @(posedge ref_clk_i);
        end while (pready_o !== 1'b1);
        rd        = prdata_o;
        er        = pslverr_o;
        psel_i    <= 1'b0;
        penable_i <= 1'b0;
    endtask

    task automatic wr(logic [7:0] a, logic [31:0] d);
        apb(1'b1, a, d);
    endtask

    task automatic rdchk(logic [7:0] a, logic [31:0] e, string nm);
        apb(1'b0, a, 32'h0000_0000);
        chk_word(nm, e, rd);
    endtask

    // one output sample, then one idle edge so the flag has landed
    task automatic smp(accel_type x, accel_type y, accel_type z);
        @(posedge ref_clk_i);
        sample_valid_i <= 1'b1;
        sample_i       <= '{z: z, y: y, x: x};
        @(posedge ref_clk_i);
        sample_valid_i <= 1'b0;
        @(posedge ref_clk_i);
    endtask

    task automatic t_reset();
        rdchk(a_cfg, 32'h0000_0000, "config");
        rdchk(a_ths, 32'h0000_0000, "threshold");
        rdchk(a_cnt, 32'h0000_0000, "setting");
        rdchk(a_mode, 32'h0000_0001, "clear mode");
        rdchk(a_stat, 32'h0000_0000, "status");
        rdchk(a_mask, 32'h0000_0000, "mask");
        wr(a_src, 32'h0000_00FF);
        chk_bit("source write error", 1'b0, er);
        rdchk(a_src, 32'h0000_0000, "source");
        apb(1'b0, 8'h88, 32'h0000_0000);
        chk_bit("unmapped read error", 1'b1, er);
        chk_word("unmapped data", 32'h0000_0000, rd);
        apb(1'b1, 8'h88, 32'h0000_00FF);
        chk_bit("unmapped write error", 1'b1, er);
        $display("done reset");
    endtask

    task automatic t_disabled();
        wr(a_ths, 32'h0000_0008);
        wr(a_cfg, 32'h0000_0040);
        smp(hi, hi, hi);
        chk_bit("motion none", 1'b0, event_active_o);
        rdchk(a_src, 32'h0000_0000, "none flags");
        wr(a_cfg, 32'h0000_0000);
        smp(lo, lo, lo);
        chk_bit("freefall none", 1'b0, event_active_o);
        wr(a_cfg, 32'h0000_0008);
        smp(lo, lo, lo);
        chk_bit("zero setting", 1'b1, event_active_o);
        smp(hi, lo, lo);
        chk_bit("zero cleared", 1'b0, event_active_o);
        $display("done disabled");
    endtask

    task automatic t_motion_clear();
        wr(a_cnt, 32'h0000_0002);
        wr(a_cfg, 32'h0000_0048);
        smp(hi, hi, lo);
        chk_bit("first sample", 1'b0, event_active_o);
        smp(hi, hi, lo);
        chk_bit("second sample", 1'b1, event_active_o);
        rdchk(a_src, 32'h0000_0082, "x only flags");
        chk_bit("after read", 1'b1, event_active_o);
        smp(ng, lo, lo);
        rdchk(a_src, 32'h0000_0083, "negative x");
        smp(lo, hi, lo);
        chk_bit("condition gone", 1'b0, event_active_o);
        $display("done motion clear");
    endtask

    task automatic t_motion_dec();
        wr(a_mode, 32'h0000_0000);
        wr(a_cnt, 32'h0000_0003);
        wr(a_cfg, 32'h0000_0058);
        smp(lo, hi, lo);
        smp(lo, hi, lo);
        chk_bit("two of three", 1'b0, event_active_o);
        smp(lo, hi, lo);
        chk_bit("y alone", 1'b1, event_active_o);
        smp(lo, lo, lo);
        chk_bit("first decrement", 1'b1, event_active_o);
        smp(lo, lo, lo);
        smp(lo, lo, lo);
        chk_bit("counted down", 1'b0, event_active_o);
        wr(a_mode, 32'h0000_0001);
        $display("done motion decrement");
    endtask

    task automatic t_ff_unlatched();
        wr(a_cnt, 32'h0000_0002);
        wr(a_cfg, 32'h0000_0018);
        smp(lo, hi, lo);
        smp(lo, hi, lo);
        chk_bit("y high blocks", 1'b0, event_active_o);
        smp(lo, lo, hi);
        smp(lo, lo, hi);
        chk_bit("z ignored", 1'b1, event_active_o);
        rdchk(a_src, 32'h0000_0080, "freefall source");
        chk_bit("read keeps", 1'b1, event_active_o);
        smp(hi, lo, lo);
        chk_bit("clears at once", 1'b0, event_active_o);
        rdchk(a_src, 32'h0000_0002, "live x");
        smp(lo, lo, lo);
        chk_bit("no early set", 1'b0, event_active_o);
        smp(lo, lo, lo);
        chk_bit("set after delay", 1'b1, event_active_o);
        smp(hi, lo, lo);
        $display("done freefall unlatched");
    endtask

    task automatic t_ff_latched();
        wr(a_cfg, 32'h0000_0098);
        smp(lo, lo, lo);
        smp(lo, lo, lo);
        smp(ng, lo, lo);
        chk_bit("latched hold", 1'b1, event_active_o);
        rdchk(a_src, 32'h0000_0080, "frozen flags");
        rdchk(a_src, 32'h0000_0000, "read cleared");
        chk_bit("flag cleared", 1'b0, event_active_o);
        smp(ng, lo, lo);
        rdchk(a_src, 32'h0000_0003, "flags resume");
        smp(lo, lo, lo);
        chk_bit("rearm delay", 1'b0, event_active_o);
        smp(lo, lo, lo);
        chk_bit("rearmed", 1'b1, event_active_o);
        rdchk(a_src, 32'h0000_0080, "second event");
        smp(hi, lo, lo);
        $display("done freefall latched");
    endtask

    task automatic t_motion_latched();
        wr(a_cnt, 32'h0000_0001);
        wr(a_cfg, 32'h0000_00C8);
        smp(hi, lo, lo);
        smp(ng, lo, lo);
        chk_bit("motion latched", 1'b1, event_active_o);
        rdchk(a_src, 32'h0000_0082, "held flags");
        rdchk(a_src, 32'h0000_0000, "all cleared");
        chk_bit("motion cleared", 1'b0, event_active_o);
        smp(lo, lo, lo);
        $display("done motion latched");
    endtask

    task automatic t_irq();
        wr(a_stat, 32'h0000_0001);
        rdchk(a_stat, 32'h0000_0000, "status cleared");
        wr(a_cfg, 32'h0000_0048);
        smp(hi, lo, lo);
        rdchk(a_stat, 32'h0000_0001, "status set");
        chk_bit("masked irq", 1'b0, irq_o);
        wr(a_mask, 32'h0000_0001);
        rdchk(a_mask, 32'h0000_0001, "mask");
        chk_bit("irq raised", 1'b1, irq_o);
        wr(a_stat, 32'h0000_0001);
        rdchk(a_stat, 32'h0000_0000, "status w1c");
        chk_bit("irq dropped", 1'b0, irq_o);
        smp(lo, lo, lo);
        smp(hi, lo, lo);
        rdchk(a_stat, 32'h0000_0001, "status again");
        chk_bit("irq on event", 1'b1, irq_o);
        wr(a_stat, 32'h0000_0001);
        smp(lo, lo, lo);
        $display("done interrupt");
    endtask

    initial begin
        rst_i          = 1'b1;
        psel_i         = 1'b0;
        penable_i      = 1'b0;
        pwrite_i       = 1'b0;
        paddr_i        = 8'h00;
        pwdata_i       = 32'h0000_0000;
        sample_valid_i = 1'b0;
        sample_i       = '0;
        fails          = 0;
        cmp_count      = 0;
        repeat (16) @(posedge ref_clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_disabled();
        t_motion_clear();
        t_motion_dec();
        t_ff_unlatched();
        t_ff_latched();
        t_motion_latched();
        t_irq();
        close_out();
    end
endmodule
